// ==== rtl/hmt_pkg.sv ====
// Constants, register map and types of the hundred-ms timer bank
package hmt_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned SCAN_MAX_S = 4;
   localparam int unsigned NUM_TIMERS = 256;
   localparam logic [7:0] LAST_IDX = 8'hFF;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_SET_VALUE = 8'h08;
   localparam logic [7:0] ADDR_PV_DATA = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_TICKS = 8'h14;
   // ------------------------------------------------------------
   // Field positions, values and responses
   // ------------------------------------------------------------
   localparam int unsigned CTRL_W = 3;
   localparam int unsigned CMD_W = 15;
   localparam int unsigned STAT_DONE_BIT = 16;
   localparam int unsigned STAT_ERR_BIT = 17;
   localparam int unsigned STAT_BUSY_BIT = 18;
   localparam logic [15:0] PV_RST_BCD = 16'h9999;
   localparam logic [15:0] PV_RST_BIN = 16'hFFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_EXEC = 3'h0,
      OP_RESET_CMD = 3'h1,
      OP_FORCE_SET = 3'h2,
      OP_FORCE_RESET = 3'h3,
      OP_PV_WRITE = 3'h4,
      OP_POWER_RESTORE = 3'h5
   } hmt_op_t;
   typedef enum logic [1:0] {
      SEC_NORMAL = 2'h0,
      SEC_INTERLOCK = 2'h1,
      SEC_JUMP = 2'h2
   } hmt_sec_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SWEEP = 2'b10
   } hmt_state_t;
   // CTRL bits [2:0]: protect, io_memory_retain_bit, run_mode
   typedef struct packed {
      logic protect;
      logic io_memory_retain_bit;
      logic run_mode;
   } hmt_ctrl_t;
   // CMD bits [14:0]: op, section, input level, binary variant, index
   typedef struct packed {
      hmt_op_t op;
      hmt_sec_t sec;
      logic in_lvl;
      logic binary;
      logic [7:0] idx;
   } hmt_cmd_t;
   typedef struct packed {
      logic [15:0] present_value;
      logic done;
      logic prev_in;
      logic pending;
      logic [15:0] stamp;
   } hmt_entry_t;
endpackage

// ==== rtl/hmt_tick_base.sv ====
// Free-running 100 ms tick counter
`timescale 1ns/1ps
`default_nettype none
module hmt_tick_base #(
   parameter int unsigned TICK_CYCLES = hmt_pkg::TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   output logic [15:0] ticks_out
);
   localparam int unsigned CW = $clog2(TICK_CYCLES);
   localparam logic [CW-1:0] DIV_LAST = CW'(TICK_CYCLES - 1);
   localparam logic [CW-1:0] DIV_ONE = CW'(1);

   typedef struct packed {
      logic [CW-1:0] div;
      logic [15:0] ticks;
   } hmt_tb_t;

   hmt_tb_t s_ff;
   hmt_tb_t nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (s_ff.div == DIV_LAST) begin
         nxt_s.div = '0;
         nxt_s.ticks = s_ff.ticks + 16'h0001;
      end else begin
         nxt_s.div = s_ff.div + DIV_ONE;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ticks_out = s_ff.ticks;
endmodule
`default_nettype wire

// ==== rtl/hmt_timer_bank.sv ====
// Bank of 256 decrementing 100 ms timers behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module hmt_timer_bank #(
   parameter int unsigned TICK_CYCLES = hmt_pkg::TICK_CYCLES
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic [7:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [7:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      hmt_pkg::hmt_state_t st;
      logic [7:0] swp_idx;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      hmt_pkg::hmt_ctrl_t ctrl;
      logic [15:0] set_value;
      logic [15:0] pv_data;
      logic [15:0] last_pv;
      logic last_done;
      logic error_flag;
      logic lst_fire;
      logic lst_mode;
      logic [14:0] lst_cmd;
      logic [15:0] lst_sv;
   } hmt_regs_t;

   localparam hmt_regs_t RST_S = '{st: hmt_pkg::ST_SWEEP, ctrl: '0, default: '0};

   hmt_regs_t s_ff;
   hmt_regs_t nxt_s;
   hmt_pkg::hmt_entry_t mem [hmt_pkg::NUM_TIMERS];
   hmt_pkg::hmt_entry_t ent;
   hmt_pkg::hmt_entry_t upd;
   hmt_pkg::hmt_entry_t mem_wd;
   hmt_pkg::hmt_cmd_t cmd;
   hmt_pkg::hmt_ctrl_t new_ctrl;
   logic mem_we;
   logic [7:0] mem_wa;
   logic [15:0] now;
   logic [15:0] elapsed;
   logic bad;
   logic [31:0] ctrl_m;
   logic [31:0] sv_m;
   logic [31:0] pv_m;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic bcd_ok(input logic [15:0] v);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (v[i*4 +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // 100 ms ticks from a free-running base
   hmt_tick_base #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_in(REF_CLK_IN),
      .rst_in(RESET_IN),
      .ticks_out(now)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.lst_fire = 1'b0;
      nxt_s.lst_mode = 1'b0;
      mem_we = 1'b0;
      mem_wa = s_ff.swp_idx;
      mem_wd = '0;
      cmd = hmt_pkg::hmt_cmd_t'(s_ff.wdata[hmt_pkg::CMD_W-1:0]);
      ent = mem[cmd.idx];
      upd = ent;
      elapsed = '0;
      bad = 1'b0;
      ctrl_m = bmerge({29'h0, s_ff.ctrl}, s_ff.wdata, s_ff.wstrb);
      sv_m = bmerge({16'h0, s_ff.set_value}, s_ff.wdata, s_ff.wstrb);
      pv_m = bmerge({16'h0, s_ff.pv_data}, s_ff.wdata, s_ff.wstrb);
      new_ctrl = hmt_pkg::hmt_ctrl_t'(ctrl_m[hmt_pkg::CTRL_W-1:0]);
      // Clearing sweep, one timer per cycle
      if (s_ff.st == hmt_pkg::ST_SWEEP) begin
         mem_we = 1'b1;
         nxt_s.swp_idx = s_ff.swp_idx + 8'h01;
         if (s_ff.swp_idx == hmt_pkg::LAST_IDX) begin
            nxt_s.st = hmt_pkg::ST_IDLE;
         end
      end
      // Write address and data, taken in either order
      if (S_AXI_AWVALID_IN && s_ff.awready) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.awaddr = S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && s_ff.wready) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wdata = S_AXI_WDATA_IN;
         nxt_s.wstrb = S_AXI_WSTRB_IN;
      end
      if (s_ff.bvalid && S_AXI_BREADY_IN) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_ff.aw_got && s_ff.w_got) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = hmt_pkg::RESP_OKAY;
         case (s_ff.awaddr)
            hmt_pkg::ADDR_CTRL: begin
               nxt_s.ctrl = new_ctrl;
               if ((new_ctrl.run_mode != s_ff.ctrl.run_mode)
                   && !new_ctrl.io_memory_retain_bit) begin
                  nxt_s.st = hmt_pkg::ST_SWEEP;
                  nxt_s.swp_idx = '0;
                  nxt_s.lst_mode = 1'b1;
               end
            end
            hmt_pkg::ADDR_SET_VALUE: begin
               nxt_s.set_value = sv_m[15:0];
            end
            hmt_pkg::ADDR_PV_DATA: begin
               nxt_s.pv_data = pv_m[15:0];
            end
            hmt_pkg::ADDR_CMD: begin
               if (s_ff.st == hmt_pkg::ST_IDLE) begin
                  mem_we = 1'b1;
                  mem_wa = cmd.idx;
                  nxt_s.lst_fire = 1'b1;
                  nxt_s.lst_cmd = s_ff.wdata[hmt_pkg::CMD_W-1:0];
                  nxt_s.lst_sv = s_ff.set_value;
                  case (cmd.op)
                     hmt_pkg::OP_EXEC: begin
                        bad = !cmd.binary && !bcd_ok(s_ff.set_value);
                        nxt_s.error_flag = bad;
                        if (cmd.sec == hmt_pkg::SEC_JUMP) begin
                           upd = ent;
                        end else if (cmd.sec == hmt_pkg::SEC_INTERLOCK) begin
                           upd.present_value = s_ff.set_value;
                           upd.done = 1'b0;
                           upd.prev_in = 1'b0;
                           upd.pending = 1'b0;
                        end else if (bad) begin
                           upd = ent;
                        end else if (!cmd.in_lvl) begin
                           // Reset only; a restart needs a later execution
                           upd.present_value = s_ff.set_value;
                           upd.done = 1'b0;
                           upd.prev_in = 1'b0;
                           upd.pending = 1'b0;
                        end else begin
                           if (ent.pending) begin
                              upd.present_value = s_ff.set_value;
                              upd.pending = 1'b0;
                           end else if (ent.prev_in) begin
                              // Whole elapsed ticks, saturating at zero
                              elapsed = now - ent.stamp;
                              upd.present_value = (ent.present_value > elapsed) ?
                                 (ent.present_value - elapsed) : 16'h0000;
                           end
                           upd.prev_in = 1'b1;
                           upd.stamp = now;
                           upd.done = (upd.present_value == 16'h0000);
                        end
                     end
                     hmt_pkg::OP_RESET_CMD: begin
                        upd.present_value = cmd.binary ? hmt_pkg::PV_RST_BIN :
                                            hmt_pkg::PV_RST_BCD;
                        upd.done = 1'b0;
                        upd.pending = 1'b1;
                     end
                     hmt_pkg::OP_FORCE_SET: begin
                        upd.present_value = 16'h0000;
                        upd.done = 1'b1;
                     end
                     hmt_pkg::OP_FORCE_RESET: begin
                        upd.present_value = s_ff.set_value;
                        upd.done = 1'b0;
                     end
                     hmt_pkg::OP_PV_WRITE: begin
                        upd.present_value = s_ff.pv_data;
                        upd.stamp = now;
                     end
                     hmt_pkg::OP_POWER_RESTORE: begin
                        mem_we = 1'b0;
                        if (!(s_ff.ctrl.io_memory_retain_bit && s_ff.ctrl.protect)) begin
                           nxt_s.st = hmt_pkg::ST_SWEEP;
                           nxt_s.swp_idx = '0;
                        end
                     end
                     default: begin
                        mem_we = 1'b0;
                     end
                  endcase
                  if (mem_we) begin
                     mem_wd = upd;
                     nxt_s.last_pv = upd.present_value;
                     nxt_s.last_done = upd.done;
                  end
               end
            end
            hmt_pkg::ADDR_STATUS, hmt_pkg::ADDR_TICKS: begin
               nxt_s.bresp = hmt_pkg::RESP_OKAY;
            end
            default: begin
               nxt_s.bresp = hmt_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Read channel
      if (S_AXI_ARVALID_IN && s_ff.arready) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = hmt_pkg::RESP_OKAY;
         case (S_AXI_ARADDR_IN)
            hmt_pkg::ADDR_CTRL: nxt_s.rdata = {29'h0, s_ff.ctrl};
            hmt_pkg::ADDR_CMD: nxt_s.rdata = 32'h0;
            hmt_pkg::ADDR_SET_VALUE: nxt_s.rdata = {16'h0, s_ff.set_value};
            hmt_pkg::ADDR_PV_DATA: nxt_s.rdata = {16'h0, s_ff.pv_data};
            hmt_pkg::ADDR_STATUS: begin
               nxt_s.rdata = {13'h0, (s_ff.st == hmt_pkg::ST_SWEEP), s_ff.error_flag,
                              s_ff.last_done, s_ff.last_pv};
            end
            hmt_pkg::ADDR_TICKS: nxt_s.rdata = {16'h0, now};
            default: begin
               nxt_s.rdata = 32'h0;
               nxt_s.rresp = hmt_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_ff.rvalid && S_AXI_RREADY_IN) begin
         nxt_s.rvalid = 1'b0;
      end
      nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
      nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
      nxt_s.arready = !nxt_s.rvalid;
   end

   // ------------------------------------------------------------
   // Registers and timer memory
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         s_ff <= RST_S;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign S_AXI_AWREADY_OUT = s_ff.awready;
   assign S_AXI_WREADY_OUT = s_ff.wready;
   assign S_AXI_BRESP_OUT = s_ff.bresp;
   assign S_AXI_BVALID_OUT = s_ff.bvalid;
   assign S_AXI_ARREADY_OUT = s_ff.arready;
   assign S_AXI_RDATA_OUT = s_ff.rdata;
   assign S_AXI_RRESP_OUT = s_ff.rresp;
   assign S_AXI_RVALID_OUT = s_ff.rvalid;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   hmt_pkg::hmt_cmd_t lc;
   hmt_pkg::hmt_entry_t le;
   assign lc = hmt_pkg::hmt_cmd_t'(s_ff.lst_cmd);
   assign le = mem[lc.idx];

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (RESET_IN);

   write_resp_a: assert property (s_ff.aw_got && s_ff.w_got |=> s_ff.bvalid)
      else $error("write response missing");
   read_resp_a: assert property (S_AXI_ARVALID_IN && s_ff.arready |=> s_ff.rvalid && !s_ff.arready)
      else $error("read response missing");
   bcd_error_a: assert property (s_ff.lst_fire && lc.op == hmt_pkg::OP_EXEC |->
      s_ff.error_flag == (!lc.binary && !bcd_ok(s_ff.lst_sv))) else $error("error flag wrong");
   input_low_a: assert property (s_ff.lst_fire && lc.op == hmt_pkg::OP_EXEC &&
      lc.sec == hmt_pkg::SEC_NORMAL && !lc.in_lvl && !s_ff.error_flag |->
      le.present_value == s_ff.lst_sv && !le.done) else $error("input low not reset");
   done_match_a: assert property (s_ff.lst_fire && lc.op == hmt_pkg::OP_EXEC &&
      lc.sec == hmt_pkg::SEC_NORMAL && lc.in_lvl && !s_ff.error_flag |->
      le.done == (le.present_value == 16'h0000)) else $error("done flag mismatch");
   interlock_a: assert property (s_ff.lst_fire && lc.op == hmt_pkg::OP_EXEC &&
      lc.sec == hmt_pkg::SEC_INTERLOCK |-> le.present_value == s_ff.lst_sv && !le.done)
      else $error("interlock not reset");
   reset_cmd_a: assert property (s_ff.lst_fire && lc.op == hmt_pkg::OP_RESET_CMD |->
      le.pending && !le.done && le.present_value ==
      (lc.binary ? hmt_pkg::PV_RST_BIN : hmt_pkg::PV_RST_BCD)) else $error("reset cmd wrong");
   force_set_a: assert property (s_ff.lst_fire && lc.op == hmt_pkg::OP_FORCE_SET |->
      le.done && le.present_value == 16'h0000) else $error("forced set wrong");
   mode_clear_a: assert property (s_ff.lst_mode |-> s_ff.st == hmt_pkg::ST_SWEEP &&
      s_ff.swp_idx == 8'h00 ##1 s_ff.swp_idx == 8'h01) else $error("mode clear not started");

   timeout_c: cover property (s_ff.lst_fire && lc.op == hmt_pkg::OP_EXEC && le.done);
   reset_cmd_c: cover property (s_ff.lst_fire && lc.op == hmt_pkg::OP_RESET_CMD);
   sweep_c: cover property (s_ff.st == hmt_pkg::ST_SWEEP ##1 s_ff.st == hmt_pkg::ST_IDLE);
endmodule
`default_nettype wire

// ==== dv/hmt_seq_model.sv ====
// Program-scan sequencer model: AXI4-Lite master that issues timer instructions
`timescale 1ns/1ps
`default_nettype none
module hmt_seq_model (
   input wire logic clk_in,
   output logic [7:0] awaddr_out,
   output logic awvalid_out,
   input wire logic awready_in,
   output logic [31:0] wdata_out,
   output logic [3:0] wstrb_out,
   output logic wvalid_out,
   input wire logic wready_in,
   input wire logic [1:0] bresp_in,
   input wire logic bvalid_in,
   output logic bready_out,
   output logic [7:0] araddr_out,
   output logic arvalid_out,
   input wire logic arready_in,
   input wire logic [31:0] rdata_in,
   input wire logic [1:0] rresp_in,
   input wire logic rvalid_in,
   output logic rready_out
);
   initial begin
      awaddr_out = 8'h00;
      awvalid_out = 1'h0;
      wdata_out = 32'h0;
      wstrb_out = 4'h0;
      wvalid_out = 1'h0;
      bready_out = 1'h0;
      araddr_out = 8'h00;
      arvalid_out = 1'h0;
      rready_out = 1'h0;
   end
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
      output logic t);
      int n;
      begin
         t = 1'h1;
         r = 2'h0;
         @(posedge clk_in);
         awaddr_out <= a;
         awvalid_out <= 1'h1;
         wdata_out <= d;
         wstrb_out <= 4'hF;
         wvalid_out <= 1'h1;
         bready_out <= 1'h1;
         // Bounded step keeps every scan far below four seconds
         for (n = 0; n < 64 && t; n++) begin
            @(posedge clk_in);
            if (awready_in === 1'h1) awvalid_out <= 1'h0;
            if (wready_in === 1'h1) wvalid_out <= 1'h0;
            if (bvalid_in === 1'h1) begin
               r = bresp_in;
               bready_out <= 1'h0;
               t = 1'h0;
            end
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
      output logic t);
      int n;
      begin
         t = 1'h1;
         r = 2'h0;
         d = 32'h0;
         @(posedge clk_in);
         araddr_out <= a;
         arvalid_out <= 1'h1;
         rready_out <= 1'h1;
         for (n = 0; n < 64 && t; n++) begin
            @(posedge clk_in);
            if (arready_in === 1'h1) arvalid_out <= 1'h0;
            if (rvalid_in === 1'h1) begin
               d = rdata_in;
               r = rresp_in;
               rready_out <= 1'h0;
               t = 1'h0;
            end
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the hundred-ms timer bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int miscompares = 0;
   int comparisons = 0;
   always #12.5 clk = ~clk;
   hmt_timer_bank #(.TICK_CYCLES(8)) dut (.REF_CLK_IN(clk), .RESET_IN(rst),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
   hmt_seq_model m (.clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid),
      .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid),
      .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
      .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
      .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
   task automatic end_sim();
      begin
         $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
         if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      logic [1:0] r;
      logic t;
      begin
         m.wr(a, v, r, t);
         if (t !== 1'h0) begin
            miscompares++;
            end_sim();
         end
         `CHK(r, e)
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] e);
      logic [1:0] r;
      logic t;
      begin
         m.rd(a, v, r, t);
         if (t !== 1'h0) begin
            miscompares++;
            end_sim();
         end
         `CHK(r, e)
      end
   endtask
   // Issue one instruction, then check error, done and a present-value window
   task automatic ex(input logic [2:0] op, input logic [1:0] sec, input logic i, input logic b,
      input logic [7:0] n, input logic [1:0] ed, input logic [15:0] lo, input logic [15:0] hi);
      logic [31:0] s;
      begin
         wr(hmt_pkg::ADDR_CMD, {17'h0, op, sec, i, b, n}, hmt_pkg::RESP_OKAY);
         rd(hmt_pkg::ADDR_STATUS, s, hmt_pkg::RESP_OKAY);
         `CHK({s[17:16], s[15:0] >= lo && s[15:0] <= hi}, {ed, 1'h1})
      end
   endtask
   task automatic xo(input logic [2:0] op, input logic [1:0] sec, input logic i, input logic b,
      input logic [7:0] n, input logic [1:0] ed, input logic [15:0] v);
      ex(op, sec, i, b, n, ed, v, v);
   endtask
   task automatic xn(input logic i, input logic b, input logic [7:0] n, input logic [1:0] ed,
      input logic [15:0] v);
      xo(hmt_pkg::OP_EXEC, hmt_pkg::SEC_NORMAL, i, b, n, ed, v);
   endtask
   task automatic sv(input logic [15:0] v);
      wr(hmt_pkg::ADDR_SET_VALUE, {16'h0, v}, hmt_pkg::RESP_OKAY);
   endtask
   task automatic fs(input logic [7:0] n);
      xo(hmt_pkg::OP_FORCE_SET, hmt_pkg::SEC_NORMAL, 1'h0, 1'h0, n, 2'h1, 16'h0);
   endtask
   task automatic jump_section_start(input logic [7:0] n, input logic [1:0] ed, input logic [15:0] v);
      xo(hmt_pkg::OP_EXEC, hmt_pkg::SEC_JUMP, 1'h1, 1'h0, n, ed, v);
   endtask
   task automatic pwr();
      wr(hmt_pkg::ADDR_CMD, {17'h0, hmt_pkg::OP_POWER_RESTORE, 12'h000}, hmt_pkg::RESP_OKAY);
   endtask
   task automatic wait_idle();
      logic [31:0] s;
      int n;
      begin
         s = 32'hFFFFFFFF;
         for (n = 0; n < 400 && s[hmt_pkg::STAT_BUSY_BIT] !== 1'h0; n++) begin
            rd(hmt_pkg::ADDR_STATUS, s, hmt_pkg::RESP_OKAY);
         end
         if (s[hmt_pkg::STAT_BUSY_BIT] !== 1'h0) begin
            miscompares++;
            end_sim();
         end
      end
   endtask
   // Each timer index is driven by one instruction at a time
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      wait_idle();
      rd(hmt_pkg::ADDR_CTRL, d, hmt_pkg::RESP_OKAY);
      `CHK(d, 32'h0)
      wr(8'h20, 32'h0, hmt_pkg::RESP_SLVERR);
      rd(8'h20, d, hmt_pkg::RESP_SLVERR);
      `CHK(d, 32'h0)
      wr(hmt_pkg::ADDR_CTRL, 32'h1, hmt_pkg::RESP_OKAY);
      wait_idle();
      sv(16'h0014);
      xn(1'h0, 1'h1, 8'h02, 2'h0, 16'h0014);
      xn(1'h1, 1'h1, 8'h02, 2'h0, 16'h0014);
      repeat (40) @(posedge clk);
      ex(hmt_pkg::OP_EXEC, 2'h0, 1'h1, 1'h1, 8'h02, 2'h0, 16'h000C, 16'h000F);
      repeat (200) @(posedge clk);
      rd(hmt_pkg::ADDR_TICKS, d, hmt_pkg::RESP_OKAY);
      `CHK(d[15:0] != 16'h0000, 1'h1)
      rd(hmt_pkg::ADDR_CMD, d, hmt_pkg::RESP_OKAY);
      `CHK(d, 32'h0)
      xn(1'h1, 1'h1, 8'h02, 2'h1, 16'h0);
      xn(1'h1, 1'h1, 8'h02, 2'h1, 16'h0);
      wr(hmt_pkg::ADDR_PV_DATA, 32'h5, hmt_pkg::RESP_OKAY);
      wr(hmt_pkg::ADDR_CMD, {17'h0, hmt_pkg::OP_PV_WRITE, 4'h3, 8'h02}, hmt_pkg::RESP_OKAY);
      ex(hmt_pkg::OP_EXEC, 2'h0, 1'h1, 1'h1, 8'h02, 2'h0, 16'h0004, 16'h0005);
      xn(1'h0, 1'h1, 8'h02, 2'h0, 16'h0014);
      sv(16'h0000);
      xn(1'h0, 1'h0, 8'h08, 2'h0, 16'h0);
      xn(1'h1, 1'h0, 8'h08, 2'h1, 16'h0);
      sv(16'h00A0);
      xn(1'h0, 1'h0, 8'h06, 2'h2, 16'h0);
      xn(1'h0, 1'h1, 8'h06, 2'h0, 16'h00A0);
      sv(16'h9999);
      xn(1'h0, 1'h0, 8'h07, 2'h0, 16'h9999);
      sv(16'hFFFF);
      xn(1'h0, 1'h1, 8'h07, 2'h0, 16'hFFFF);
      sv(16'h0042);
      xo(hmt_pkg::OP_RESET_CMD, 2'h0, 1'h0, 1'h0, 8'h04, 2'h0, 16'h9999);
      xn(1'h1, 1'h0, 8'h04, 2'h0, 16'h0042);
      xo(hmt_pkg::OP_RESET_CMD, 2'h0, 1'h0, 1'h1, 8'h05, 2'h0, 16'hFFFF);
      xn(1'h1, 1'h1, 8'h05, 2'h0, 16'h0042);
      fs(8'h04);
      xo(hmt_pkg::OP_EXEC, hmt_pkg::SEC_INTERLOCK, 1'h1, 1'h0, 8'h04, 2'h0, 16'h0042);
      fs(8'h04);
      jump_section_start(8'h04, 2'h1, 16'h0);
      xo(hmt_pkg::OP_FORCE_RESET, 2'h0, 1'h0, 1'h0, 8'h04, 2'h0, 16'h0042);
      xn(1'h0, 1'h0, 8'hFF, 2'h0, 16'h0042);
      fs(8'h00);
      jump_section_start(8'hFF, 2'h0, 16'h0042);
      fs(8'h09);
      wr(hmt_pkg::ADDR_CTRL, 32'h2, hmt_pkg::RESP_OKAY);
      jump_section_start(8'h09, 2'h1, 16'h0);
      wr(hmt_pkg::ADDR_CTRL, 32'h1, hmt_pkg::RESP_OKAY);
      wait_idle();
      jump_section_start(8'h09, 2'h0, 16'h0);
      fs(8'h09);
      wr(hmt_pkg::ADDR_CTRL, 32'h7, hmt_pkg::RESP_OKAY);
      rd(hmt_pkg::ADDR_CTRL, d, hmt_pkg::RESP_OKAY);
      `CHK(d, 32'h7)
      pwr();
      wait_idle();
      jump_section_start(8'h09, 2'h1, 16'h0);
      wr(hmt_pkg::ADDR_CTRL, 32'h3, hmt_pkg::RESP_OKAY);
      pwr();
      wait_idle();
      jump_section_start(8'h09, 2'h0, 16'h0);
      end_sim();
   end
endmodule
`undef CHK
`default_nettype wire
